// ===== design/apdc_consts.svh
/*
  Constants of the auxiliary port direction control block: register byte
  offsets, field positions and reset values.
  Assumes it is included by bare name from the package and the top module.
*/
`ifndef APDC_CONSTS_SVH
`define APDC_CONSTS_SVH

`define APDC_PORT_W 6
`define APDC_DIR_OFS 8'h00
`define APDC_LVL_OFS 8'h04
`define APDC_CMD_OFS 8'h08
`define APDC_IN_OFS 8'h0C
`define APDC_TEST_OFS 8'h10
`define APDC_STAT_OFS 8'h14
`define APDC_FUNC_OFS 8'h18
`define APDC_ADC_OFS 8'h1C
`define APDC_DIR_RST 6'h07
`define APDC_LVL_RST 6'h00
`define APDC_CMD_IDX_LSB 0
`define APDC_CMD_LVL_BIT 8
`define APDC_TEST_MASK_LSB 0
`define APDC_TEST_CMP_LSB 8
`define APDC_TEST_OR_BIT 16
`define APDC_FUNC_SOFT_BIT 0
`define APDC_FUNC_HPWM_LSB 1
`define APDC_ADC_REQ_LSB 0
`define APDC_ADC_EN_LSB 8
`define APDC_SOFT_PWM_PIN 5
`define APDC_HPWM_TOP_PIN 5
`define APDC_ANALOG_PINS 3

`endif

// ===== design/apdc_pkg.sv
/*
  Types of the auxiliary port direction control block.
  Assumes the constants header is on the include path.
*/
`include "apdc_consts.svh"

package apdc_pkg;

  typedef enum logic [3:0] {
    APDC_R_DIR = 4'h0,
    APDC_R_LVL = 4'h1,
    APDC_R_CMD = 4'h3,
    APDC_R_IN = 4'h2,
    APDC_R_TEST = 4'h6,
    APDC_R_STAT = 4'h7,
    APDC_R_FUNC = 4'h5,
    APDC_R_ADC = 4'h4,
    APDC_R_NONE = 4'hC
  } apdc_reg_t;

  typedef logic [`APDC_PORT_W-1:0] apdc_bits_t;

  typedef struct packed {
    apdc_bits_t dir;
    apdc_bits_t lat;
    apdc_bits_t test_mask;
    apdc_bits_t test_cmp;
    logic test_or;
    logic [4:0] func_en;
    logic [2:0] adc_req;
    logic [2:0] adc_en;
    logic test_hit;
    apdc_bits_t pin_out;
    apdc_bits_t pin_oe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apdc_state_t;

  typedef struct packed {
    apdc_bits_t s1;
    apdc_bits_t s2;
    apdc_bits_t s3;
    apdc_bits_t level;
  } apdc_sync_state_t;

endpackage

// ===== design/apdc_sync_if.sv
/*
  Carrier between the top module and the pin input synchroniser.
  Assumes both ends run on the same system clock.
*/
interface apdc_sync_if;
  logic [5:0] raw;
  logic [5:0] level;
  modport user (output raw, input level);
  modport sync (input raw, output level);
endinterface

// ===== design/apdc_sync.sv
/*
  Three-stage synchroniser for the six port pins; a level is accepted once
  the second and third stages agree.
  Assumes pins are asynchronous to the clock and reset is synchronous.
*/
`include "apdc_consts.svh"
module apdc_sync (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Pin levels in, filtered levels out.
  apdc_sync_if.sync port
);
  import apdc_pkg::*;

  apdc_sync_state_t state_ff;
  apdc_sync_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.s1 = port.raw;
    nxt_state.s2 = state_ff.s1;
    nxt_state.s3 = state_ff.s2;
    for (int i = 0; i < `APDC_PORT_W; i++) begin
      if (state_ff.s2[i] == state_ff.s3[i]) begin
        nxt_state.level[i] = state_ff.s3[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign port.level = state_ff.level;
endmodule

// ===== design/apdc_port.sv
/*
  Six-bit auxiliary port with direction register, set-high and set-low
  commands, static input tests, analogue channel gating and PWM pin takeover,
  all reached over an APB slave.
  Assumes one 125 MHz clock, synchronous active-high reset, PWM waves and the
  primary output engine on the same clock, and pins arriving asynchronously.
*/
// The implementer's own choices: the APB slave port and the register addresses.
`include "apdc_consts.svh"
module apdc_port (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port pins.
  input wire apdc_pkg::apdc_bits_t pin_in,
  output apdc_pkg::apdc_bits_t pin_out,
  output apdc_pkg::apdc_bits_t pin_oe,
  // Primary output engine on bits zero to two.
  input wire logic [2:0] prim_active,
  input wire logic [2:0] prim_level,
  // PWM waves.
  input wire logic [3:0] hpwm_wave,
  input wire logic soft_pwm_wave,
  // Analogue channel enables and condition test result.
  output logic [2:0] analog_channel_en,
  output logic cond_hit
);
  import apdc_pkg::*;

  apdc_state_t state_ff;
  apdc_state_t nxt_state;
  apdc_sync_if sync_bus ();
  apdc_bits_t in_level;
  apdc_bits_t dir_w;
  apdc_bits_t lat_w;
  apdc_bits_t force_out;
  apdc_bits_t drive;
  apdc_reg_t rsel;
  logic setup;
  logic wr;
  logic [2:0] cmd_idx;
  logic [31:0] rdata;

  function automatic apdc_reg_t apdc_decode(input logic [7:0] a);
    apdc_reg_t r;
    unique case (a)
      `APDC_DIR_OFS: r = APDC_R_DIR;
      `APDC_LVL_OFS: r = APDC_R_LVL;
      `APDC_CMD_OFS: r = APDC_R_CMD;
      `APDC_IN_OFS: r = APDC_R_IN;
      `APDC_TEST_OFS: r = APDC_R_TEST;
      `APDC_STAT_OFS: r = APDC_R_STAT;
      `APDC_FUNC_OFS: r = APDC_R_FUNC;
      `APDC_ADC_OFS: r = APDC_R_ADC;
      default: r = APDC_R_NONE;
    endcase
    return r;
  endfunction

  apdc_sync u_sync (
    .clock(clock),
    .rst(rst),
    .port(sync_bus.sync)
  );

  assign sync_bus.raw = pin_in;
  assign in_level = sync_bus.level;

  always_comb begin
    nxt_state = state_ff;
    setup = psel & ~penable;
    wr = psel & penable & state_ff.pready & pwrite;
    rsel = apdc_decode(paddr);
    cmd_idx = pwdata[`APDC_CMD_IDX_LSB +: 3];
    rdata = 32'h00000000;
    unique case (rsel)
      APDC_R_DIR: rdata[5:0] = state_ff.dir;
      APDC_R_LVL: rdata[5:0] = state_ff.lat;
      APDC_R_IN: rdata[5:0] = in_level;
      APDC_R_TEST: begin
        rdata[`APDC_TEST_MASK_LSB +: 6] = state_ff.test_mask;
        rdata[`APDC_TEST_CMP_LSB +: 6] = state_ff.test_cmp;
        rdata[`APDC_TEST_OR_BIT] = state_ff.test_or;
      end
      APDC_R_STAT: rdata[0] = state_ff.test_hit;
      APDC_R_FUNC: rdata[4:0] = state_ff.func_en;
      APDC_R_ADC: begin
        rdata[`APDC_ADC_REQ_LSB +: 3] = state_ff.adc_req;
        rdata[`APDC_ADC_EN_LSB +: 3] = state_ff.adc_en;
      end
      APDC_R_CMD, APDC_R_NONE: rdata = 32'h00000000;
    endcase
    // Bus answer: one access cycle after each setup cycle.
    nxt_state.pready = setup;
    nxt_state.pslverr = setup & (rsel == APDC_R_NONE);
    if (setup & ~pwrite) begin
      nxt_state.prdata = rdata;
    end
    // Direction and level writes; only the direction register clears a direction bit.
    dir_w = state_ff.dir;
    lat_w = state_ff.lat;
    if (wr & (rsel == APDC_R_DIR)) begin
      dir_w = pwdata[5:0];
    end
    if (wr & (rsel == APDC_R_LVL)) begin
      lat_w = pwdata[5:0];
    end
    if (wr & (rsel == APDC_R_CMD) & (cmd_idx < 3'h6)) begin
      dir_w[cmd_idx] = 1'b1;
      lat_w[cmd_idx] = pwdata[`APDC_CMD_LVL_BIT];
    end
    nxt_state.lat = lat_w;
    if (wr & (rsel == APDC_R_TEST)) begin
      nxt_state.test_mask = pwdata[`APDC_TEST_MASK_LSB +: 6];
      nxt_state.test_cmp = pwdata[`APDC_TEST_CMP_LSB +: 6];
      nxt_state.test_or = pwdata[`APDC_TEST_OR_BIT];
    end
    if (wr & (rsel == APDC_R_FUNC)) begin
      nxt_state.func_en = pwdata[4:0];
    end
    if (wr & (rsel == APDC_R_ADC)) begin
      nxt_state.adc_req = pwdata[`APDC_ADC_REQ_LSB +: 3];
    end
    // Pins taken by PWM or the primary engine become outputs; set beats clear.
    force_out = '0;
    force_out[2:0] = prim_active;
    if (state_ff.func_en[`APDC_FUNC_SOFT_BIT]) begin
      force_out[`APDC_SOFT_PWM_PIN] = 1'b1;
    end
    for (int k = 0; k < 4; k++) begin
      if (state_ff.func_en[`APDC_FUNC_HPWM_LSB + k]) begin
        force_out[`APDC_HPWM_TOP_PIN - k] = 1'b1;
      end
    end
    nxt_state.dir = dir_w | force_out;
    // Level mux: hardware PWM, then software PWM, then primary engine, then latch.
    drive = lat_w;
    for (int i = 0; i < 3; i++) begin
      if (prim_active[i]) begin
        drive[i] = prim_level[i];
      end
    end
    if (state_ff.func_en[`APDC_FUNC_SOFT_BIT]) begin
      drive[`APDC_SOFT_PWM_PIN] = soft_pwm_wave;
    end
    for (int k = 0; k < 4; k++) begin
      if (state_ff.func_en[`APDC_FUNC_HPWM_LSB + k]) begin
        drive[`APDC_HPWM_TOP_PIN - k] = hpwm_wave[k];
      end
    end
    nxt_state.pin_out = drive;
    nxt_state.pin_oe = nxt_state.dir;
    // Analogue channels open only on pins already set to input.
    nxt_state.adc_en = state_ff.adc_req & ~state_ff.dir[`APDC_ANALOG_PINS-1:0];
    // Condition test over this port alone.
    if (state_ff.test_or) begin
      nxt_state.test_hit = |(~(in_level ^ state_ff.test_cmp) & state_ff.test_mask);
    end else begin
      nxt_state.test_hit = ((in_level ^ state_ff.test_cmp) & state_ff.test_mask) == 6'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= '0;
      state_ff.dir <= `APDC_DIR_RST;
      state_ff.pin_oe <= `APDC_DIR_RST;
      state_ff.lat <= `APDC_LVL_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign prdata = state_ff.prdata;
  assign pready = state_ff.pready;
  assign pslverr = state_ff.pslverr;
  assign pin_out = state_ff.pin_out;
  assign pin_oe = state_ff.pin_oe;
  assign analog_channel_en = state_ff.adc_en;
  assign cond_hit = state_ff.test_hit;
endmodule

// ===== verif/apdc_port_props.sv
/*
  Checker of the port block, watching its top ports.
  Assumes the design package is compiled first.
*/
module apdc_port_chk (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and side inputs.
  input wire apdc_pkg::apdc_bits_t pin_out,
  input wire apdc_pkg::apdc_bits_t pin_oe,
  input wire logic [2:0] prim_active,
  input wire logic [2:0] prim_level,
  input wire logic [2:0] analog_channel_en
);
  import apdc_pkg::*;
  logic [4:0] fn_ff;
  logic wr;
  logic dwr;
  logic cw;
  logic [5:0] fm;
  assign wr = psel & penable & pready & pwrite & ~pslverr;
  assign dwr = wr && paddr == 8'h00;
  assign cw = wr && paddr == 8'h08 && pwdata[2:0] < 3'h6 && fn_ff == 5'h00 && prim_active == 3'h0;
  assign fm = {fn_ff[1], fn_ff[2], fn_ff[3], fn_ff[4], 2'h0};
  always_ff @(posedge clock) begin
    fn_ff <= rst ? 5'h00 : ((wr && paddr == 8'h18) ? pwdata[4:0] : fn_ff);
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_dir_write;
    dwr && fn_ff == 5'h00 && prim_active == 3'h0 |=> pin_oe == $past(pwdata[5:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write not applied");
  property p_cmd_high;
    cw && pwdata[8] |=> pin_oe[$past(pwdata[2:0])] && pin_out[$past(pwdata[2:0])];
  endproperty
  a_cmd_high: assert property (p_cmd_high) else $error("set-high command failed");
  property p_cmd_low;
    cw && !pwdata[8] |=> pin_oe[$past(pwdata[2:0])] && !pin_out[$past(pwdata[2:0])];
  endproperty
  a_cmd_low: assert property (p_cmd_low) else $error("set-low command failed");
  property p_reset;
    disable iff (1'b0) rst |=> pin_oe == 6'h07;
  endproperty
  a_reset: assert property (p_reset) else $error("wrong reset direction");
  property p_boot;
    |(~pin_oe[2:0] & $past(pin_oe[2:0])) |-> $past(dwr) || $past(dwr, 2);
  endproperty
  a_boot: assert property (p_boot) else $error("low bits left output without write");
  property p_soft;
    fn_ff[0] && $past(fn_ff[0], 3) |-> pin_oe[5];
  endproperty
  a_soft: assert property (p_soft) else $error("soft pwm pin not output");
  property p_hpwm;
    (fm & $past(fm, 3)) != 6'h00 |-> (pin_oe & fm & $past(fm, 3)) == (fm & $past(fm, 3));
  endproperty
  a_hpwm: assert property (p_hpwm) else $error("hardware pwm pin not output");
  property p_analog;
    (analog_channel_en & pin_oe[2:0] & $past(pin_oe[2:0])) == 3'h0;
  endproperty
  a_analog: assert property (p_analog) else $error("analogue channel on output pin");
  property p_prim;
    prim_active[1:0] == 2'h3 && $past(prim_active[1:0]) == 2'h3 |-> pin_out[1:0] == $past(prim_level[1:0]);
  endproperty
  a_prim: assert property (p_prim) else $error("primary level not on pin");
endmodule
bind apdc_port apdc_port_chk u_chk (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
  .prim_active(prim_active), .prim_level(prim_level), .analog_channel_en(analog_channel_en));

// ===== verif/apdc_ext_model.sv
/*
  Board circuits on the port pins.
  Assumes pins driven by the block override the board level.
*/
module apdc_ext_model (
  // Pins.
  input wire apdc_pkg::apdc_bits_t pin_out,
  input wire apdc_pkg::apdc_bits_t pin_oe,
  input wire apdc_pkg::apdc_bits_t drive,
  output apdc_pkg::apdc_bits_t pin_in
);
  import apdc_pkg::*;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule

// ===== verif/aux_port_direction_control_tb.sv
/*
  Testbench of the port block.
  Assumes design, checker and board model compiled first.
*/
module aux_port_direction_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import apdc_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  apdc_bits_t pin_in;
  apdc_bits_t pin_out;
  apdc_bits_t pin_oe;
  apdc_bits_t drive = 6'h05;
  logic [2:0] prim_active = 3'h0;
  logic [2:0] prim_level = 3'h0;
  logic [3:0] hpwm_wave = 4'h5;
  logic soft_pwm_wave = 1'b1;
  logic [2:0] analog_channel_en;
  logic cond_hit;
  logic [31:0] rdat;
  logic rerr;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [51:0] rows [8] = '{{8'h00, 32'h3F, 6'h3F, 6'h00}, {8'h00, 32'h00, 6'h00, 6'h00},
    {8'h08, 32'h103, 6'h08, 6'h08}, {8'h08, 32'h105, 6'h28, 6'h28}, {8'h08, 32'h005, 6'h28, 6'h08},
    {8'h08, 32'h000, 6'h29, 6'h08}, {8'h08, 32'h106, 6'h29, 6'h08}, {8'h00, 32'h15, 6'h15, 6'h00}};
  apdc_port u_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .prim_active(prim_active), .prim_level(prim_level), .hpwm_wave(hpwm_wave),
    .soft_pwm_wave(soft_pwm_wave), .analog_channel_en(analog_channel_en), .cond_hit(cond_hit));
  apdc_ext_model u_ext (.pin_out(pin_out), .pin_oe(pin_oe), .drive(drive), .pin_in(pin_in));
  initial begin
    forever #4 clock = ~clock;
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  initial begin
    idle(5000);
    error_cnt++;
    finish_test();
  end
  initial begin
    logic [7:0] a;
    logic [31:0] d;
    logic [5:0] eo;
    logic [5:0] eq;
    idle(3);
    rst <= 1'b0;
    idle(1);
    chk(pin_oe, 6'h07);
    apb(1'b0, 8'h00, 32'h0);
    chk(rdat[5:0], 6'h07);
    apb(1'b0, 8'h20, 32'h0);
    chk({5'h00, rerr}, 6'h01);
    foreach (rows[i]) begin
      {a, d, eo, eq} = rows[i];
      apb(1'b1, a, d);
      idle(2);
      chk(pin_oe, eo);
      chk(pin_out & pin_oe, eq);
    end
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h10, 32'h0303);
    idle(8);
    chk({5'h00, cond_hit}, 6'h00);
    apb(1'b1, 8'h10, 32'h10303);
    idle(4);
    chk({5'h00, cond_hit}, 6'h01);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rdat[5:0], 6'h05);
    apb(1'b1, 8'h1C, 32'h7);
    idle(2);
    chk({3'h0, analog_channel_en}, 6'h07);
    apb(1'b1, 8'h00, 32'h2);
    idle(2);
    chk({3'h0, analog_channel_en}, 6'h05);
    prim_active <= 3'h3;
    prim_level <= 3'h2;
    idle(3);
    chk(pin_oe, 6'h03);
    chk(pin_out & 6'h03, 6'h02);
    prim_active <= 3'h0;
    apb(1'b1, 8'h18, 32'h1E);
    apb(1'b1, 8'h00, 32'h0);
    idle(3);
    chk(pin_oe, 6'h3C);
    chk(pin_out & 6'h3C, 6'h28);
    apb(1'b1, 8'h18, 32'h1);
    apb(1'b1, 8'h00, 32'h0);
    idle(3);
    chk(pin_oe, 6'h20);
    chk(pin_out & 6'h20, 6'h20);
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b1, 8'h04, 32'h3F);
    apb(1'b1, 8'h00, 32'h3F);
    idle(2);
    chk(pin_oe, 6'h3F);
    chk(pin_out, 6'h3F);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdat[5:0], 6'h3F);
    idle(4);
    apb(1'b0, 8'h14, 32'h0);
    chk(rdat[5:0], 6'h01);
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    idle(1);
    chk(pin_oe, 6'h07);
    chk(pin_out, 6'h00);
    finish_test();
  end
endmodule
